// [periodic_timer_core.sv]
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module periodic_timer_core
  import ptm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_tick_high,
  input  wire logic       i_tick_sub,
  input  wire logic       i_external_clock_input,
  output logic [7:0]      o_rdata,
  output logic            o_timer_output_pin,
  output logic            o_timer_output_inverted,
  output logic            o_irq_a,
  output logic            o_irq_p
);

  localparam int HI_W = CNT_W - 8;

  typedef struct packed {
    logic [7:0]       ctrl0;
    logic [7:0]       ctrl1;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_p;
    logic [7:0]       buf8;
    logic [1:0]       sys_div;
    logic [3:0]       h16;
    logic [5:0]       h64;
    logic             ext_s1;
    logic             ext_s2;
    logic             ext_d;
    logic             pin;
    logic [7:0]       rdata;
    logic             out_p;
    logic             out_n;
    logic             irq_a;
    logic             irq_p;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
    hi_byte = 8'h00;
    hi_byte[HI_W-1:0] = v[CNT_W-1:8];
  endfunction : hi_byte

  function automatic logic [CNT_W-1:0] join_val(input logic [7:0] hi,
                                                input logic [7:0] lo);
    join_val = {hi[HI_W-1:0], lo};
  endfunction : join_val

  // Counter clock enable for the selected source
  function automatic logic tick_sel(input logic [2:0] cks,
                                    input state_s     s,
                                    input clk_src_s   c);
    case (cks)
      CKS_SYS4:  tick_sel = (s.sys_div == SYS_DIV4);
      CKS_SYS:   tick_sel = 1'b1;
      CKS_H16:   tick_sel = c.tick_high && (s.h16 == H_DIV16);
      CKS_H64:   tick_sel = c.tick_high && (s.h64 == H_DIV64);
      CKS_SUB0,
      CKS_SUB1:  tick_sel = c.tick_sub;
      // One tick per synchronised edge
      CKS_EXT_R: tick_sel = s.ext_s2 && !s.ext_d;
      CKS_EXT_F: tick_sel = !s.ext_s2 && s.ext_d;
      default:   tick_sel = 1'b0;
    endcase
  endfunction : tick_sel

  reg_req_s req;
  clk_src_s src;
  logic     on_rise;
  logic     tick;
  logic     match_a;
  logic     match_p;
  logic     ovf;
  logic     clr;
  logic     pin_v;
  logic [1:0] mode;
  logic [1:0] iofn;

  always_comb begin
    req       = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    src       = '{tick_high: i_tick_high,
                  tick_sub:  i_tick_sub,
                  ext_clk:   i_external_clock_input};
    st_nxt    = st_r;
    mode      = st_r.ctrl1[C1_MODE_HI:C1_MODE_LO];
    iofn      = st_r.ctrl1[C1_IO_HI:C1_IO_LO];
    on_rise   = 1'b0;
    // Prescalers run freely
    st_nxt.sys_div = st_r.sys_div + 2'h1;
    if (src.tick_high) begin
      st_nxt.h16 = st_r.h16 + 4'h1;
      st_nxt.h64 = st_r.h64 + 6'h1;
    end
    // Two-stage synchroniser then edge detect
    st_nxt.ext_s1 = src.ext_clk;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_d  = st_r.ext_s2;
    tick = tick_sel(st_r.ctrl0[C0_CKS_HI:C0_CKS_LO], st_r, src);
    // Comparators over all counter bits
    match_a = (st_r.cnt == st_r.cmp_a);
    match_p = (st_r.cnt == st_r.cmp_p);
    ovf     = (st_r.cnt == {CNT_W{1'b1}});
    if (mode == MODE_PWM) begin
      clr = match_p;
    end else if (st_r.ctrl1[C1_CCLR]) begin
      clr = match_a;
    end else if (st_r.cmp_p == '0) begin
      // Zero period wraps at the top, else count sticks at zero
      clr = ovf;
    end else begin
      clr = match_p;
    end
    // Counting only while on and not paused
    st_nxt.irq_a = 1'b0;
    st_nxt.irq_p = 1'b0;
    if (st_r.ctrl0[C0_ON] && !st_r.ctrl0[C0_PAUSE] && tick) begin
      st_nxt.cnt   = clr ? '0 : st_r.cnt + 1'b1;
      st_nxt.irq_a = match_a;
      st_nxt.irq_p = match_p;
      if (mode == MODE_CMP && match_a) begin
        case (iofn)
          IO_NONE: st_nxt.pin = st_r.pin;
          IO_LOW:  st_nxt.pin = 1'b0;
          IO_HIGH: st_nxt.pin = 1'b1;
          IO_TGL:  st_nxt.pin = !st_r.pin;
          default: st_nxt.pin = st_r.pin;
        endcase
      end else if (mode == MODE_PWM && iofn == IO_HIGH) begin
        if (match_p) begin
          st_nxt.pin = st_r.ctrl1[C1_OC];
        end else if (match_a) begin
          st_nxt.pin = !st_r.ctrl1[C1_OC];
        end
      end
    end
    // Register port
    st_nxt.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_CTRL0:  st_nxt.rdata = st_r.ctrl0 & C0_MASK;
        ADDR_CTRL1:  st_nxt.rdata = st_r.ctrl1;
        ADDR_CNT_HI: begin
          st_nxt.rdata = hi_byte(st_r.cnt);
          st_nxt.buf8  = st_r.cnt[7:0];
        end
        ADDR_CA_HI: begin
          st_nxt.rdata = hi_byte(st_r.cmp_a);
          st_nxt.buf8  = st_r.cmp_a[7:0];
        end
        ADDR_CP_HI: begin
          st_nxt.rdata = hi_byte(st_r.cmp_p);
          st_nxt.buf8  = st_r.cmp_p[7:0];
        end
        ADDR_CNT_LO,
        ADDR_CA_LO,
        ADDR_CP_LO:  st_nxt.rdata = st_r.buf8;
        default:     st_nxt.rdata = 8'h00;
      endcase
    end
    if (req.wr) begin
      case (req.addr)
        ADDR_CTRL0: begin
          st_nxt.ctrl0 = req.wdata & C0_MASK;
          on_rise = req.wdata[C0_ON] && !st_r.ctrl0[C0_ON];
        end
        ADDR_CTRL1:  st_nxt.ctrl1 = req.wdata & C1_MASK;
        ADDR_CA_LO,
        ADDR_CP_LO:  st_nxt.buf8  = req.wdata;
        ADDR_CA_HI:  st_nxt.cmp_a = join_val(req.wdata, st_r.buf8);
        ADDR_CP_HI:  st_nxt.cmp_p = join_val(req.wdata, st_r.buf8);
        default:     st_nxt.buf8  = st_r.buf8;
      endcase
    end
    if (on_rise) begin
      st_nxt.cnt = '0;
      if (mode != MODE_TMR) begin
        st_nxt.pin = st_r.ctrl1[C1_OC];
      end
    end
    pin_v = (mode == MODE_TMR) ? st_nxt.pin
                               : st_nxt.pin ^ st_nxt.ctrl1[C1_POL];
    st_nxt.out_p = pin_v;
    st_nxt.out_n = !pin_v;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r       <= '0;
      st_r.ctrl0 <= C0_RESET;
      st_r.ctrl1 <= C1_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata                 = st_r.rdata;
  assign o_timer_output_pin      = st_r.out_p;
  assign o_timer_output_inverted = st_r.out_n;
  assign o_irq_a                 = st_r.irq_a;
  assign o_irq_p                 = st_r.irq_p;

endmodule : periodic_timer_core

// [ptm_chk.sv]
`timescale 1ns/1ps
module ptm_chk
  import ptm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_timer_output_pin,
  input wire logic       o_timer_output_inverted,
  input wire logic       o_irq_a,
  input wire logic       o_irq_p
);
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Shadow copies of both control registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      c0_r <= C0_RESET;
      c1_r <= C1_RESET;
    end else if (i_wr && i_addr == ADDR_CTRL0) c0_r <= i_wdata;
    else if (i_wr && i_addr == ADDR_CTRL1) c1_r <= i_wdata;
  end
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  sequence s_on_rise;
    i_wr && i_addr == ADDR_CTRL0 && i_wdata[C0_ON] && !c0_r[C0_ON]
      && c1_r[C1_MODE_HI:C1_MODE_LO] != MODE_TMR;
  endsequence
  a_ctrl0_read: assert property (s_rd(ADDR_CTRL0) |=>
    o_rdata == (c0_r & C0_MASK)) else $error("ctrl0 read");
  a_ctrl1_read: assert property (s_rd(ADDR_CTRL1) |=>
    o_rdata == (c1_r & C1_MASK)) else $error("ctrl1 read");
  a_high_unused: assert property (i_rd && i_addr[0] &&
    i_addr > ADDR_CTRL1 |=> (o_rdata >> (CNT_W - 8)) == 8'h00)
    else $error("high byte bits");
  a_irq_a_once: assert property (o_irq_a |=> !o_irq_a)
    else $error("irq a long");
  a_irq_p_once: assert property (o_irq_p |=> !o_irq_p)
    else $error("irq p long");
  a_pin_inverse: assert property (!$past(i_rst) |->
    o_timer_output_inverted != o_timer_output_pin) else $error("pin pair");
  a_hold_quiet: assert property (
    (c0_r[C0_PAUSE] || !c0_r[C0_ON]) [*4] |-> !o_irq_a && !o_irq_p)
    else $error("irq while held");
  a_on_level: assert property (s_on_rise |=> ##[0:1]
    o_timer_output_pin == (c1_r[C1_OC] ^ c1_r[C1_POL]))
    else $error("pin not initial");
endmodule : ptm_chk

// [ptm_ext_src.sv]
`timescale 1ns/1ps
module ptm_ext_src #(
  parameter int HALF = 2
) (
  input  wire logic i_mclk,
  input  wire logic i_run,
  output logic      o_ext
);
  int cnt_r = 0;
  initial o_ext = 1'b0;
  // Still while not run, else toggles every HALF cycles
  always @(posedge i_mclk) begin
    if (i_run) cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
    if (i_run && cnt_r == HALF - 1) o_ext <= ~o_ext;
  end
endmodule : ptm_ext_src

// [ptm_pkg.sv]
package ptm_pkg;

  // Register indexes on the byte-wide port
  localparam logic [2:0] ADDR_CTRL0  = 3'h0;
  localparam logic [2:0] ADDR_CTRL1  = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CA_LO  = 3'h4;
  localparam logic [2:0] ADDR_CA_HI  = 3'h5;
  localparam logic [2:0] ADDR_CP_LO  = 3'h6;
  localparam logic [2:0] ADDR_CP_HI  = 3'h7;

  // Control register 0 fields
  localparam int C0_PAUSE  = 7;
  localparam int C0_CKS_HI = 6;
  localparam int C0_CKS_LO = 4;
  localparam int C0_ON     = 3;
  localparam logic [7:0] C0_MASK  = 8'hf8;
  localparam logic [7:0] C0_RESET = 8'h00;

  // Control register 1 fields
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_IO_HI   = 5;
  localparam int C1_IO_LO   = 4;
  localparam int C1_OC      = 3;
  localparam int C1_POL     = 2;
  localparam int C1_CCLR    = 0;
  localparam logic [7:0] C1_MASK  = 8'hfd;
  localparam logic [7:0] C1_RESET = 8'h00;

  localparam logic [2:0] CKS_SYS4  = 3'h0;
  localparam logic [2:0] CKS_SYS   = 3'h1;
  localparam logic [2:0] CKS_H16   = 3'h2;
  localparam logic [2:0] CKS_H64   = 3'h3;
  localparam logic [2:0] CKS_SUB0  = 3'h4;
  localparam logic [2:0] CKS_SUB1  = 3'h5;
  localparam logic [2:0] CKS_EXT_R = 3'h6;
  localparam logic [2:0] CKS_EXT_F = 3'h7;

  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_UNDEF = 2'h1;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TMR   = 2'h3;

  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW  = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TGL  = 2'h3;

  localparam logic [1:0] SYS_DIV4  = 2'h3;
  localparam logic [3:0] H_DIV16   = 4'hf;
  localparam logic [5:0] H_DIV64   = 6'h3f;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic tick_high;
    logic tick_sub;
    logic ext_clk;
  } clk_src_s;

endpackage : ptm_pkg

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import ptm_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic rd_d = 1'b0, run = 1'b0, i_tick_high = 1'b0, i_tick_sub = 1'b0;
  logic i_external_clock_input, o_irq_a, o_irq_p;
  logic o_timer_output_pin, o_timer_output_inverted;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, exp_q[$];
  logic [15:0] v;
  int failures = 0, n_compared = 0, seed = 80721, na = 0, np = 0, n0;
  int cpt[8] = '{4, 1, 32, 128, 2, 2, 4, 4};
  periodic_timer_core #(.CNT_W(10)) u_dut (
    .i_mclk                 (i_mclk),
    .i_rst                  (i_rst),
    .i_addr                 (i_addr),
    .i_wdata                (i_wdata),
    .i_wr                   (i_wr),
    .i_rd                   (i_rd),
    .i_tick_high            (i_tick_high),
    .i_tick_sub             (i_tick_sub),
    .i_external_clock_input (i_external_clock_input),
    .o_rdata                (o_rdata),
    .o_timer_output_pin     (o_timer_output_pin),
    .o_timer_output_inverted(o_timer_output_inverted),
    .o_irq_a                (o_irq_a),
    .o_irq_p                (o_irq_p)
  );
  ptm_ext_src u_ext (
    .i_mclk(i_mclk),
    .i_run (run),
    .o_ext (i_external_clock_input)
  );
  // Internal clock enables pulse every second cycle
  always @(posedge i_mclk) begin
    i_tick_high <= !i_tick_high;
    i_tick_sub  <= !i_tick_sub;
  end
  initial forever #12.5 i_mclk = ~i_mclk;
  initial begin
    #750000;
    failures++;
    finish_test();
  end
  task automatic chk(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  // Read expectations queue up; one gap cycle after every access
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    if (!w) exp_q.push_back(d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= w;
    i_rd    <= !w;
    cyc(1);
    i_wr    <= 1'b0;
    i_rd    <= 1'b0;
    cyc(1);
  endtask : acc
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  always @(posedge i_mclk) begin
    rd_d <= i_rd;
    if (rd_d) chk(o_rdata === exp_q.pop_front());
  end
  always @(negedge i_mclk) begin
    if (o_irq_a) na++;
    if (o_irq_p) np++;
  end
  initial begin
    cyc(10);
    i_rst <= 1'b0;
    cyc(1);
    acc(1'b0, ADDR_CTRL0, 8'h00);
    acc(1'b1, ADDR_CTRL0, 8'hff);
    acc(1'b0, ADDR_CTRL0, 8'hf8);
    acc(1'b1, ADDR_CNT_HI, 8'hff);
    acc(1'b0, ADDR_CNT_HI, 8'h00);
    acc(1'b0, ADDR_CNT_LO, 8'h00);
    acc(1'b1, ADDR_CTRL1, 8'hff);
    acc(1'b0, ADDR_CTRL1, 8'hfd);
    for (int k = 4; k < 8; k += 2) begin
      v = 16'($random(seed));
      acc(1'b1, 3'(k), v[7:0]);
      acc(1'b1, 3'(k + 1), v[15:8]);
      acc(1'b0, 3'(k + 1), {6'h00, v[9:8]});
      acc(1'b0, 3'(k), v[7:0]);
    end
    acc(1'b1, ADDR_CP_LO, 8'h09);
    acc(1'b1, ADDR_CP_HI, 8'h00);
    acc(1'b1, ADDR_CTRL1, 8'hc0);
    for (int i = 0; i < 8; i++) begin
      run <= (i > 5);
      acc(1'b1, ADDR_CTRL0, 8'h00);
      acc(1'b1, ADDR_CTRL0, {1'b0, 3'(i), 4'h8});
      cyc(12 * cpt[i]);
      n0 = np;
      cyc(50 * cpt[i]);
      chk(np - n0 == 5);
    end
    run <= 1'b0;
    acc(1'b1, ADDR_CTRL0, 8'h98);
    cyc(4);
    n0 = np;
    cyc(100);
    chk(np == n0);
    acc(1'b1, ADDR_CTRL0, 8'h90);
    acc(1'b1, ADDR_CTRL0, 8'h98);
    acc(1'b0, ADDR_CNT_HI, 8'h00);
    acc(1'b0, ADDR_CNT_LO, 8'h00);
    acc(1'b1, ADDR_CTRL0, 8'h18);
    acc(1'b1, ADDR_CTRL0, 8'h98);
    acc(1'b0, ADDR_CNT_HI, 8'h00);
    acc(1'b0, ADDR_CNT_LO, 8'h02);
    acc(1'b1, ADDR_CTRL0, 8'h18);
    acc(1'b1, ADDR_CTRL0, 8'h10);
    acc(1'b0, ADDR_CNT_HI, 8'h00);
    acc(1'b0, ADDR_CNT_LO, 8'h04);
    acc(1'b1, ADDR_CP_LO, 8'h00);
    acc(1'b1, ADDR_CP_HI, 8'h00);
    acc(1'b1, ADDR_CTRL0, 8'h18);
    cyc(1100);
    n0 = np;
    cyc(2048);
    chk(np - n0 == 2);
    acc(1'b1, ADDR_CA_LO, 8'h04);
    acc(1'b1, ADDR_CA_HI, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, ADDR_CTRL0, 8'h10);
      acc(1'b1, ADDR_CTRL1, {2'h0, 2'(i), !i[1], 3'h1});
      acc(1'b1, ADDR_CTRL0, 8'h18);
      cyc(1);
      chk(o_timer_output_pin === !i[1]);
      n0 = na;
      for (int t = 0; t < 20 && na == n0; t++) cyc(1);
      chk(na != n0);
      cyc(2);
      chk(o_timer_output_pin === (i != 1));
    end
    // PWM: active on P match, inactive on A match, clear on P
    acc(1'b1, ADDR_CTRL0, 8'h10);
    acc(1'b1, ADDR_CP_LO, 8'h09);
    acc(1'b1, ADDR_CP_HI, 8'h00);
    acc(1'b1, ADDR_CTRL1, 8'ha9);
    acc(1'b1, ADDR_CTRL0, 8'h18);
    cyc(1);
    chk(o_timer_output_pin === 1'b1);
    n0 = np;
    for (int t = 0; t < 20 && np == n0; t++) cyc(1);
    chk(np != n0);
    cyc(2);
    chk(o_timer_output_pin === 1'b1);
    cyc(4);
    chk(o_timer_output_pin === 1'b0);
    finish_test();
  end
endmodule : tb
bind periodic_timer_core ptm_chk #(.CNT_W(CNT_W)) u_chk (
  .i_mclk                 (i_mclk),
  .i_rst                  (i_rst),
  .i_addr                 (i_addr),
  .i_wdata                (i_wdata),
  .i_wr                   (i_wr),
  .i_rd                   (i_rd),
  .o_rdata                (o_rdata),
  .o_timer_output_pin     (o_timer_output_pin),
  .o_timer_output_inverted(o_timer_output_inverted),
  .o_irq_a                (o_irq_a),
  .o_irq_p                (o_irq_p)
);
